// *** lsfb_pkg.sv ***
/*
 * Package for the link status flag bank: register offsets, field layout,
 * reset values and the packed event carrier.
 * Assumes a 32-bit APB slave on a single clock.
 */
`default_nettype none

package lsfb_pkg;

    // Register byte offsets
    localparam logic [7:0] LSFB_OFF_COMM = 8'h00;
    localparam logic [7:0] LSFB_OFF_ERR_CODE = 8'h04;
    localparam logic [7:0] LSFB_OFF_NET = 8'h08;
    localparam logic [7:0] LSFB_OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] LSFB_OFF_IRQ_MASK = 8'h10;

    // Field positions in the comm flag register
    localparam int LSFB_BIT_ACCESS_END = 0;
    localparam int LSFB_BIT_SERIAL_ERR = 1;
    localparam int LSFB_BIT_SERIAL_RX = 2;
    localparam int LSFB_BIT_SERIAL_IDLE = 3;
    localparam int LSFB_BIT_ALARM = 4;
    localparam int LSFB_BIT_PORT_MODE = 5;

    // Field positions in the network flag register
    localparam int LSFB_NET_LINKS = 5;
    localparam int LSFB_RIO_MASTERS = 4;
    localparam int LSFB_BIT_RIO_BASE = 8;

    // Interrupt event bits
    localparam int LSFB_IRQ_BITS = 5;
    localparam int LSFB_IRQ_ACCESS_ERR = 0;
    localparam int LSFB_IRQ_SERIAL_ERR = 1;
    localparam int LSFB_IRQ_SERIAL_RX = 2;
    localparam int LSFB_IRQ_NET_ERR = 3;
    localparam int LSFB_IRQ_RIO_ERR = 4;

    localparam int LSFB_ALARM_RELAYS = 2048;
    localparam int LSFB_CODE_W = 16;

    // Reset values
    localparam logic LSFB_RST_FLAG = 1'b0;
    localparam logic LSFB_RST_IDLE = 1'b1;
    localparam logic [LSFB_CODE_W-1:0] LSFB_RST_CODE = 16'h0000;
    localparam logic [LSFB_IRQ_BITS-1:0] LSFB_RST_MASK = 5'h00;

    // Events reported by the controller, all single-cycle pulses except the levels transmitting and port_serial_mode
    typedef struct packed {
        logic access_done;
        logic access_error;
        logic [LSFB_CODE_W-1:0] access_code;
        logic serial_error;
        logic transmit_start;
        logic end_code_received;
        logic transmitting;
        logic port_serial_mode;
        logic [LSFB_NET_LINKS-1:0] net_tx_error;
        logic [LSFB_NET_LINKS-1:0] net_setting_error;
        logic [LSFB_RIO_MASTERS-1:0] rio_tx_error;
        logic [LSFB_RIO_MASTERS-1:0] rio_setting_error;
    } lsfb_event_type;

endpackage

`default_nettype wire

// *** lsfb_flag_bank.sv ***
/*
 * Link status flag bank: read-only status flags and error code word for
 * remote memory access, the serial port, the alarm relays, network links
 * and remote I/O masters, with sticky interrupt status behind an APB slave.
 * Assumes APB signals synchronous to clk_sys and events from the scan logic.
 */
// Summary of operation
// - Access end flag is 0 after a clean remote access, 1 after an error.
// - On access error the error code is stored in the error code word.
// - Serial port error flag sets when a serial communication error occurs.
// - Serial port error flag clears when the transmit instruction starts sending.
// - Serial receive flag sets when the end code is received.
// - Serial send flag is 1 while idle, 0 while transmitting.
// - Alarm summary is 1 while any of 2048 alarm relays is active.
// - Five link error flags set on transmission error of their link.
// - Link error flags also set on bad link area settings.
// - Four remote I/O flags set on transmission error of their master.
// - Remote I/O flags also set on bad master settings.
// - Receive and send flags act only in serial communication mode.
`timescale 1ns/1ps
`default_nettype none

module lsfb_flag_bank (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire lsfb_pkg::lsfb_event_type events,
    input wire logic [lsfb_pkg::LSFB_ALARM_RELAYS-1:0] error_alarm_relays,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import lsfb_pkg::*;

    logic remote_access_end_flag;
    logic [LSFB_CODE_W-1:0] remote_access_error_code_word;
    logic serial_port_error_flag;
    logic serial_receive_flag;
    logic serial_send_idle_flag;
    logic error_alarm_summary_flag;
    logic port_mode;
    logic [LSFB_NET_LINKS-1:0] net_link_error_flag;
    logic [LSFB_RIO_MASTERS-1:0] remote_io_error_flag;
    logic [LSFB_IRQ_BITS-1:0] irq_status;
    logic [LSFB_IRQ_BITS-1:0] irq_mask;
    logic [LSFB_IRQ_BITS-1:0] next_events;
    logic access_phase;
    logic wr_mask;
    logic wr_status;
    logic [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Remote access result

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            remote_access_end_flag <= LSFB_RST_FLAG;
        end else if (events.access_done) begin
            remote_access_end_flag <= events.access_error;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            remote_access_error_code_word <= LSFB_RST_CODE;
        end else if (events.access_done && events.access_error) begin
            remote_access_error_code_word <= events.access_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial port flags

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serial_port_error_flag <= LSFB_RST_FLAG;
        end else if (events.serial_error) begin
            serial_port_error_flag <= 1'b1;
        end else if (events.transmit_start) begin
            serial_port_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port_mode <= LSFB_RST_FLAG;
        end else begin
            port_mode <= events.port_serial_mode;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serial_receive_flag <= LSFB_RST_FLAG;
        end else if (!events.port_serial_mode) begin
            serial_receive_flag <= 1'b0;
        end else if (events.end_code_received) begin
            serial_receive_flag <= 1'b1;
        end else if (events.transmit_start) begin
            serial_receive_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serial_send_idle_flag <= LSFB_RST_IDLE;
        end else begin
            serial_send_idle_flag <= !(events.port_serial_mode && events.transmitting);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm summary and network flags

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            error_alarm_summary_flag <= LSFB_RST_FLAG;
        end else begin
            error_alarm_summary_flag <= |error_alarm_relays;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            net_link_error_flag <= '0;
        end else begin
            net_link_error_flag <= net_link_error_flag | events.net_tx_error
                | events.net_setting_error;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            remote_io_error_flag <= '0;
        end else begin
            remote_io_error_flag <= remote_io_error_flag | events.rio_tx_error
                | events.rio_setting_error;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    always_comb begin
        next_events = '0;
        next_events[LSFB_IRQ_ACCESS_ERR] = events.access_done && events.access_error;
        next_events[LSFB_IRQ_SERIAL_ERR] = events.serial_error;
        next_events[LSFB_IRQ_SERIAL_RX] = events.port_serial_mode && events.end_code_received;
        next_events[LSFB_IRQ_NET_ERR] = |(events.net_tx_error | events.net_setting_error);
        next_events[LSFB_IRQ_RIO_ERR] = |(events.rio_tx_error | events.rio_setting_error);
    end

    assign access_phase = psel && penable;
    assign wr_mask = access_phase && pwrite && (paddr == LSFB_OFF_IRQ_MASK);
    assign wr_status = access_phase && pwrite && (paddr == LSFB_OFF_IRQ_STATUS);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_status <= '0;
        end else if (wr_status) begin
            irq_status <= (irq_status & ~pwdata[LSFB_IRQ_BITS-1:0]) | next_events;
        end else begin
            irq_status <= irq_status | next_events;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_mask <= LSFB_RST_MASK;
        end else if (wr_mask) begin
            irq_mask <= pwdata[LSFB_IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, no wait states: pready registered from the setup cycle

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            LSFB_OFF_COMM: begin
                next_rdata[LSFB_BIT_ACCESS_END] = remote_access_end_flag;
                next_rdata[LSFB_BIT_SERIAL_ERR] = serial_port_error_flag;
                next_rdata[LSFB_BIT_SERIAL_RX] = serial_receive_flag;
                next_rdata[LSFB_BIT_SERIAL_IDLE] = serial_send_idle_flag;
                next_rdata[LSFB_BIT_ALARM] = error_alarm_summary_flag;
                next_rdata[LSFB_BIT_PORT_MODE] = port_mode;
            end
            LSFB_OFF_ERR_CODE: begin
                next_rdata[LSFB_CODE_W-1:0] = remote_access_error_code_word;
            end
            LSFB_OFF_NET: begin
                next_rdata[LSFB_NET_LINKS-1:0] = net_link_error_flag;
                next_rdata[LSFB_BIT_RIO_BASE +: LSFB_RIO_MASTERS] = remote_io_error_flag;
            end
            LSFB_OFF_IRQ_STATUS: begin
                next_rdata[LSFB_IRQ_BITS-1:0] = irq_status;
            end
            LSFB_OFF_IRQ_MASK: begin
                next_rdata[LSFB_IRQ_BITS-1:0] = irq_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_access_fail;
        events.access_done && events.access_error;
    endsequence

    property p_end_flag;
        @(posedge clk_sys) disable iff (reset)
        events.access_done |=> remote_access_end_flag == $past(events.access_error);
    endproperty
    a_end_flag: assert property (p_end_flag) else $error("end flag wrong");

    property p_code;
        @(posedge clk_sys) disable iff (reset)
        s_access_fail |=> remote_access_error_code_word == $past(events.access_code);
    endproperty
    a_code: assert property (p_code) else $error("error code not stored");

    property p_ser_set;
        @(posedge clk_sys) disable iff (reset)
        events.serial_error |=> serial_port_error_flag;
    endproperty
    a_ser_set: assert property (p_ser_set) else $error("serial error not set");

    property p_ser_clr;
        @(posedge clk_sys) disable iff (reset)
        events.transmit_start && !events.serial_error |=> !serial_port_error_flag;
    endproperty
    a_ser_clr: assert property (p_ser_clr) else $error("serial error not cleared");

    property p_rx;
        @(posedge clk_sys) disable iff (reset)
        events.port_serial_mode && events.end_code_received |=> serial_receive_flag;
    endproperty
    a_rx: assert property (p_rx) else $error("receive flag not set");

    property p_idle;
        @(posedge clk_sys) disable iff (reset)
        1'b1 |=> serial_send_idle_flag
            == !($past(events.port_serial_mode) && $past(events.transmitting));
    endproperty
    a_idle: assert property (p_idle) else $error("send flag wrong");

    property p_alarm;
        @(posedge clk_sys) disable iff (reset)
        1'b1 |=> error_alarm_summary_flag == (|$past(error_alarm_relays));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm summary wrong");

    property p_net;
        @(posedge clk_sys) disable iff (reset)
        |(events.net_tx_error | events.net_setting_error)
            |=> |net_link_error_flag ##1 |net_link_error_flag;
    endproperty
    a_net: assert property (p_net) else $error("link flag lost");

    property p_rio;
        @(posedge clk_sys) disable iff (reset)
        |(events.rio_tx_error | events.rio_setting_error) |=> |remote_io_error_flag;
    endproperty
    a_rio: assert property (p_rio) else $error("remote io flag not set");

    property p_mode;
        @(posedge clk_sys) disable iff (reset)
        !events.port_serial_mode |=> !serial_receive_flag && serial_send_idle_flag;
    endproperty
    a_mode: assert property (p_mode) else $error("serial flags active in link mode");

    property p_unmapped;
        @(posedge clk_sys) disable iff (reset)
        psel && !penable && !pwrite && paddr > LSFB_OFF_IRQ_MASK |=> prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access_clean;
        events.access_done && !events.access_error;
    endsequence

    property p_code_keep;
        @(posedge clk_sys) disable iff (reset)
        s_access_clean |=> $stable(remote_access_error_code_word);
    endproperty
    a_code_keep: assert property (p_code_keep) else $error("code overwritten");

    property p_net_tx;
        @(posedge clk_sys) disable iff (reset)
        (|events.net_tx_error) |=> (net_link_error_flag & $past(events.net_tx_error))
            == $past(events.net_tx_error);
    endproperty
    a_net_tx: assert property (p_net_tx) else $error("link tx error not flagged");

    property p_net_cfg;
        @(posedge clk_sys) disable iff (reset)
        (|events.net_setting_error) |=> (net_link_error_flag & $past(events.net_setting_error))
            == $past(events.net_setting_error);
    endproperty
    a_net_cfg: assert property (p_net_cfg) else $error("link setting error not flagged");

    property p_rio_tx;
        @(posedge clk_sys) disable iff (reset)
        (|events.rio_tx_error) |=> (remote_io_error_flag & $past(events.rio_tx_error))
            == $past(events.rio_tx_error);
    endproperty
    a_rio_tx: assert property (p_rio_tx) else $error("master tx error not flagged");

    property p_rio_cfg;
        @(posedge clk_sys) disable iff (reset)
        (|events.rio_setting_error) |=> (remote_io_error_flag & $past(events.rio_setting_error))
            == $past(events.rio_setting_error);
    endproperty
    a_rio_cfg: assert property (p_rio_cfg) else $error("master setting error not flagged");

    property p_net_keep;
        @(posedge clk_sys) disable iff (reset)
        1'b1 |=> (net_link_error_flag & $past(net_link_error_flag)) == $past(net_link_error_flag);
    endproperty
    a_net_keep: assert property (p_net_keep) else $error("link flag dropped");

    property p_mask_keep;
        @(posedge clk_sys) disable iff (reset)
        psel && penable && pwrite && paddr != LSFB_OFF_IRQ_MASK |=> $stable(irq_mask);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask changed by other write");

    property p_ready;
        @(posedge clk_sys) disable iff (reset)
        s_setup |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle after setup");

    property p_irq_access;
        @(posedge clk_sys) disable iff (reset)
        s_access_fail |=> irq_status[LSFB_IRQ_ACCESS_ERR];
    endproperty
    a_irq_access: assert property (p_irq_access) else $error("access error not latched");

endmodule // lsfb_flag_bank

`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking testbench for the link status flag bank.
 * Assumes the flag bank answers APB with pready and takes events each edge.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end

module tb_top;
    import lsfb_pkg::*;

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    lsfb_event_type ev = '0;
    lsfb_event_type p;
    logic [LSFB_ALARM_RELAYS-1:0] relays = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] q[$];
    logic [31:0] e;
    logic [31:0] note;
    logic [15:0] code;
    int bad_count = 0;
    int n_tests = 0;
    integer seed = 32'h6ec16656;
    int idx;

    always #50 clk_sys = ~clk_sys;

    lsfb_flag_bank u_lsfb_flag_bank (
        .clk_sys(clk_sys),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .events(ev),
        .error_alarm_relays(relays),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus master and event drivers

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        q.push_back(x);
        xfer(a, 1'b0, 32'h0);
    endtask

    task automatic fire(input lsfb_event_type v);
        @(posedge clk_sys);
        ev <= lsfb_event_type'(ev | v);
        @(posedge clk_sys);
        ev <= lsfb_event_type'(ev & ~v);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Result watcher

    always @(posedge clk_sys) begin
        if (psel && penable && pready) begin
            `CHK("pslverr", 1'b0, pslverr)
            if (!pwrite) begin
                if (q.size() == 0) begin
                    `CHK("read without note", 32'h1, 32'h0)
                end else begin
                    note = q.pop_front();
                    `CHK("prdata", note, prdata)
                end
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios

    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rd(LSFB_OFF_COMM, 32'h08);
        rd(LSFB_OFF_ERR_CODE, 32'h0);
        rd(LSFB_OFF_NET, 32'h0);
        rd(LSFB_OFF_IRQ_STATUS, 32'h0);
        rd(LSFB_OFF_IRQ_MASK, 32'h0);
        rd(8'h20, 32'h0);
        xfer(LSFB_OFF_COMM, 1'b1, 32'hffffffff);
        xfer(LSFB_OFF_NET, 1'b1, 32'hffffffff);
        xfer(8'h24, 1'b1, 32'hffffffff);
        rd(LSFB_OFF_COMM, 32'h08);
        rd(LSFB_OFF_NET, 32'h0);
        rd(8'h24, 32'h0);
        // Clean access, failed access, then clean again keeping the code
        p = '0;
        p.access_done = 1'b1;
        fire(p);
        rd(LSFB_OFF_COMM, 32'h08);
        code = 16'($random(seed));
        p.access_error = 1'b1;
        p.access_code = code;
        fire(p);
        rd(LSFB_OFF_COMM, 32'h09);
        rd(LSFB_OFF_ERR_CODE, {16'h0, code});
        p = '0;
        p.access_done = 1'b1;
        p.access_code = ~code;
        fire(p);
        rd(LSFB_OFF_COMM, 32'h08);
        rd(LSFB_OFF_ERR_CODE, {16'h0, code});
        // Serial port flags in serial mode, then back out of serial mode
        ev.port_serial_mode <= 1'b1;
        rd(LSFB_OFF_COMM, 32'h28);
        p = '0;
        p.serial_error = 1'b1;
        fire(p);
        rd(LSFB_OFF_COMM, 32'h2a);
        p = '0;
        p.transmit_start = 1'b1;
        fire(p);
        rd(LSFB_OFF_COMM, 32'h28);
        p = '0;
        p.end_code_received = 1'b1;
        fire(p);
        rd(LSFB_OFF_COMM, 32'h2c);
        ev.transmitting <= 1'b1;
        rd(LSFB_OFF_COMM, 32'h24);
        ev.port_serial_mode <= 1'b0;
        rd(LSFB_OFF_COMM, 32'h08);
        ev.transmitting <= 1'b0;
        // Alarm summary at both ends and a random relay
        for (int k = 0; k < 3; k++) begin
            idx = (k == 0) ? 0 : (k == 1) ? 2047 : ($unsigned($random(seed)) % 2048);
            relays[idx] <= 1'b1;
            rd(LSFB_OFF_COMM, 32'h18);
            relays[idx] <= 1'b0;
            rd(LSFB_OFF_COMM, 32'h08);
        end
        // Link and remote I/O flags, alternating the cause
        e = 32'h0;
        for (int i = 0; i < 9; i++) begin
            p = '0;
            if (i < 5 && i % 2 == 0) p.net_tx_error[i] = 1'b1;
            if (i < 5 && i % 2 == 1) p.net_setting_error[i] = 1'b1;
            if (i >= 5 && i % 2 == 1) p.rio_tx_error[i-5] = 1'b1;
            if (i >= 5 && i % 2 == 0) p.rio_setting_error[i-5] = 1'b1;
            fire(p);
            e = e | ((i < 5) ? (32'h1 << i) : (32'h100 << (i - 5)));
            rd(LSFB_OFF_NET, e);
        end
        // Interrupt status, mask and clear
        rd(LSFB_OFF_IRQ_STATUS, 32'h1f);
        `CHK("irq", 1'b0, irq)
        xfer(LSFB_OFF_IRQ_MASK, 1'b1, 32'h04);
        rd(LSFB_OFF_IRQ_MASK, 32'h04);
        repeat (2) @(posedge clk_sys);
        `CHK("irq", 1'b1, irq)
        xfer(LSFB_OFF_IRQ_STATUS, 1'b1, 32'h04);
        repeat (2) @(posedge clk_sys);
        `CHK("irq", 1'b0, irq)
        rd(LSFB_OFF_IRQ_STATUS, 32'h1b);
        // Second reset clears sticky flags
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd(LSFB_OFF_NET, 32'h0);
        rd(LSFB_OFF_COMM, 32'h08);
        repeat (2) @(posedge clk_sys);
        summarize();
    end

endmodule // tb_top

`default_nettype wire
